// >>> rtl/aie_regs.svh
// Purpose: Register offsets, field positions, reset values and opcode patterns of the
//          accumulator execution block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Definitions only.
`ifndef AIE_REGS_SVH
`define AIE_REGS_SVH

// Byte offsets on the APB
`define AIE_OFF_INSTR     12'h000
`define AIE_OFF_ACC       12'h004
`define AIE_OFF_STATUS    12'h008
`define AIE_OFF_FADDR     12'h00C
`define AIE_OFF_FDATA     12'h010
`define AIE_OFF_RETIRED   12'h014

// Status register bit positions
`define AIE_ST_CARRY      0
`define AIE_ST_HALF       1
`define AIE_ST_ZERO       2
`define AIE_ST_ILLEGAL    3

// Reset values
`define AIE_ACC_RST       8'h00
`define AIE_INSTR_RST     14'h0000
`define AIE_FADDR_RST     7'h00

// Instruction word fields
`define AIE_INSTR_W       14
`define AIE_FIDX_W        7
`define AIE_DEST_BIT      7

// Opcode patterns, compared against the top bits of the word
`define AIE_PAT_ADD_IMM   5'h1F
`define AIE_PAT_AND_IMM   6'h39
`define AIE_PAT_ADD_REG   6'h07
`define AIE_PAT_AND_REG   6'h05

// Clock edges from taking an instruction to its retirement
`define AIE_EXEC_EDGES    3

`endif

// >>> rtl/aie_pkg.sv
// Purpose: Types shared by the accumulator execution block.
// Assumes: Nothing beyond the register header.
// Notes:   Opcode enum order carries no meaning.
package aie_pkg;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD_IMM,
        OP_AND_IMM,
        OP_ADD_REG,
        OP_AND_REG
    } aie_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OPERAND,
        ST_EXECUTE,
        ST_RESPOND
    } aie_state_t;

endpackage

// >>> rtl/aie_fmem.sv
// Purpose: File register array with registered read data.
// Assumes: One write port and one read port on the same clock.
// Notes:   Array contents are not reset; only the read register is.
`timescale 1ns/1ns

module aie_fmem #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8,
    parameter int AW    = 7
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Write port
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Read port, data one edge after the address
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] rdata_r;

    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    // Read before write: a same-edge write is seen one read later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= mem_r[raddr];
        end
    end

    assign rdata = rdata_r;

endmodule // aie_fmem

// >>> rtl/aie_core.sv
// Purpose: Executes four 8-bit accumulator instructions issued over APB.
// Assumes: pclk at 100 MHz; the APB master holds each request until pready.
// Notes:   An instruction written to the instruction register retires in one
//          instruction cycle of three pclk edges; pready marks the retirement.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "aie_regs.svh"

// Functional notes
// - add_immediate: accumulator plus literal byte into accumulator; carry, half carry, Z updated.
// - add_immediate decodes from top bits 11, nibble 111x, literal in low byte.
// - and_immediate: accumulator AND literal into accumulator; only Z changes.
// - and_immediate decodes from top bits 11, nibble 1001, literal in low byte.
// - add_register: accumulator plus file register; dest 0 accumulator, 1 file register.
// - add_register decodes from 00 0111; bit 7 dest, bits 6..0 index; all three flags.
// - and_register: accumulator AND file register, steered by dest; only Z changes.
// - and_register decodes from 00 0101; bit 7 dest, bits 6..0 index.
// - Register forms take index 0 to 127 and one destination bit.
// - add_register with dest 1 writes the file register, accumulator unchanged.
module aie_core
    import aie_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int FREG_N = 128,
    parameter int CNT_W  = 16
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Core-side view of the accumulator and flags
    output logic      [7:0]        acc_out,
    output logic                   carry_out,
    output logic                   half_carry_out,
    output logic                   zero_out,
    output logic                   retire_pulse
);

    localparam int FIDX_W = `AIE_FIDX_W;

    // Control and architectural state
    aie_state_t        state_r;
    aie_state_t        state_nxt;
    logic [13:0]       instr_r;
    logic              pend_instr_r;
    logic [7:0]        acc_r;
    logic              carry_r;
    logic              half_carry_r;
    logic              zero_r;
    logic              illegal_r;
    logic [FIDX_W-1:0] faddr_r;
    logic [CNT_W-1:0]  retired_r;
    logic              retire_r;

    // APB answer
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;
    logic              pready_r;
    logic              pslverr_r;
    logic              pslverr_nxt;

    // File register port
    logic              mem_we;
    logic [FIDX_W-1:0] mem_waddr;
    logic [FIDX_W-1:0] mem_raddr;
    logic [7:0]        mem_wdata;
    logic [7:0]        mem_rdata;

    // Request decode
    logic              apb_req;
    logic              addr_ok;
    logic              hit_instr;
    logic              hit_acc;
    logic              hit_status;
    logic              hit_faddr;
    logic              hit_fdata;
    logic              hit_retired;
    logic              wr_take;
    logic              new_op_legal;

    // Execution
    aie_op_t           exec_op;
    logic              exec_fire;
    logic [7:0]        operand;
    logic [7:0]        result;
    logic [9:0]        sum_full;
    logic              to_freg;
    logic              upd_carry;
    logic              new_carry;
    logic              new_half;
    logic              new_zero;
    logic [31:0]       rd_mux;

    // Word pattern to operation
    function automatic aie_op_t decode_op(input logic [13:0] word);
        aie_op_t op;
        op = OP_NONE;
        if (word[13:9] == `AIE_PAT_ADD_IMM) begin
            op = OP_ADD_IMM;
        end else if (word[13:8] == `AIE_PAT_AND_IMM) begin
            op = OP_AND_IMM;
        end else if (word[13:8] == `AIE_PAT_ADD_REG) begin
            op = OP_ADD_REG;
        end else if (word[13:8] == `AIE_PAT_AND_REG) begin
            op = OP_AND_REG;
        end
        return op;
    endfunction

    // Returns {carry from bit 7, carry from bit 3, sum}
    function automatic logic [9:0] add_bytes(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, b};
        low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {full[8], low[4], full[7:0]};
    endfunction

    function automatic logic reg_form(input aie_op_t op);
        return (op == OP_ADD_REG) || (op == OP_AND_REG);
    endfunction

    // Only an unanswered access phase in idle is a new request
    assign apb_req     = psel && penable && !pready_r && (state_r == ST_IDLE);
    assign hit_instr   = (paddr == `AIE_OFF_INSTR);
    assign hit_acc     = (paddr == `AIE_OFF_ACC);
    assign hit_status  = (paddr == `AIE_OFF_STATUS);
    assign hit_faddr   = (paddr == `AIE_OFF_FADDR);
    assign hit_fdata   = (paddr == `AIE_OFF_FDATA);
    assign hit_retired = (paddr == `AIE_OFF_RETIRED);
    assign addr_ok     = hit_instr || hit_acc || hit_status || hit_faddr || hit_fdata
                         || (hit_retired && !pwrite);
    assign wr_take     = apb_req && pwrite && addr_ok;
    assign new_op_legal = (decode_op(pwdata[13:0]) != OP_NONE);

    // Sequencer
    always_comb begin
        state_nxt   = state_r;
        pslverr_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (apb_req) begin
                    if (!addr_ok) begin
                        state_nxt   = ST_RESPOND;
                        pslverr_nxt = 1'b1;
                    end else if (pwrite && hit_instr) begin
                        if (new_op_legal) begin
                            state_nxt = ST_OPERAND;
                        end else begin
                            state_nxt   = ST_RESPOND;
                            pslverr_nxt = 1'b1;
                        end
                    end else if (!pwrite && hit_fdata) begin
                        state_nxt = ST_OPERAND;
                    end else begin
                        state_nxt = ST_RESPOND;
                    end
                end
            end
            // Fixed length: no stall and no discarded slot for any op
            ST_OPERAND: begin
                state_nxt = ST_EXECUTE;
            end
            ST_EXECUTE: begin
                state_nxt = ST_RESPOND;
            end
            ST_RESPOND: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Instruction capture; a refused word leaves the previous one in place
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r      <= `AIE_INSTR_RST;
            pend_instr_r <= 1'b0;
        end else if (apb_req && addr_ok && hit_instr && pwrite && new_op_legal) begin
            instr_r      <= pwdata[13:0];
            pend_instr_r <= 1'b1;
        end else if (apb_req) begin
            pend_instr_r <= 1'b0;
        end
    end

    // Datapath
    assign exec_op   = decode_op(instr_r);
    assign exec_fire = (state_r == ST_EXECUTE) && pend_instr_r;

    always_comb begin
        if (reg_form(exec_op)) begin
            operand = mem_rdata;
        end else begin
            operand = instr_r[7:0];
        end
        sum_full  = add_bytes(acc_r, operand);
        upd_carry = (exec_op == OP_ADD_IMM) || (exec_op == OP_ADD_REG);
        if (upd_carry) begin
            result = sum_full[7:0];
        end else begin
            result = acc_r & operand;
        end
        new_carry = sum_full[9];
        new_half  = sum_full[8];
        new_zero  = (result == 8'h00);
        // Immediate forms never reach the file registers
        to_freg   = reg_form(exec_op) && instr_r[`AIE_DEST_BIT];
    end

    // Accumulator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= `AIE_ACC_RST;
        end else if (wr_take && hit_acc) begin
            acc_r <= pwdata[7:0];
        end else if (exec_fire && !to_freg) begin
            acc_r <= result;
        end
    end

    // Flags; logic ops leave carry and half carry alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_r      <= 1'b0;
            half_carry_r <= 1'b0;
            zero_r       <= 1'b0;
        end else if (wr_take && hit_status) begin
            carry_r      <= pwdata[`AIE_ST_CARRY];
            half_carry_r <= pwdata[`AIE_ST_HALF];
            zero_r       <= pwdata[`AIE_ST_ZERO];
        end else if (exec_fire) begin
            zero_r <= new_zero;
            if (upd_carry) begin
                carry_r      <= new_carry;
                half_carry_r <= new_half;
            end
        end
    end

    // Sticky refused-opcode flag, write one to clear; a new refusal wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            illegal_r <= 1'b0;
        end else if (wr_take && hit_instr && !new_op_legal) begin
            illegal_r <= 1'b1;
        end else if (wr_take && hit_status && pwdata[`AIE_ST_ILLEGAL]) begin
            illegal_r <= 1'b0;
        end
    end

    // Software window onto the file registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faddr_r <= `AIE_FADDR_RST;
        end else if (wr_take && hit_faddr) begin
            faddr_r <= pwdata[FIDX_W-1:0];
        end
    end

    // Retirement count and pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retired_r <= '0;
            retire_r  <= 1'b0;
        end else begin
            retire_r <= exec_fire;
            if (exec_fire) begin
                retired_r <= retired_r + CNT_W'(1);
            end
        end
    end

    // File register port: index is the full seven-bit field
    always_comb begin
        mem_raddr = pend_instr_r ? instr_r[FIDX_W-1:0] : faddr_r;
        if (exec_fire && to_freg) begin
            mem_we    = 1'b1;
            mem_waddr = instr_r[FIDX_W-1:0];
            mem_wdata = result;
        end else begin
            mem_we    = wr_take && hit_fdata;
            mem_waddr = faddr_r;
            mem_wdata = pwdata[7:0];
        end
    end

    aie_fmem #(
        .DEPTH (FREG_N),
        .WIDTH (8),
        .AW    (FIDX_W)
    ) u_fmem (
        .clk   (pclk),
        .rst_n (presetn),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // Read data
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_instr) begin
            rd_mux[13:0] = instr_r;
        end else if (hit_acc) begin
            rd_mux[7:0] = acc_r;
        end else if (hit_status) begin
            rd_mux[`AIE_ST_CARRY]   = carry_r;
            rd_mux[`AIE_ST_HALF]    = half_carry_r;
            rd_mux[`AIE_ST_ZERO]    = zero_r;
            rd_mux[`AIE_ST_ILLEGAL] = illegal_r;
        end else if (hit_faddr) begin
            rd_mux[FIDX_W-1:0] = faddr_r;
        end else if (hit_retired) begin
            rd_mux[CNT_W-1:0] = retired_r;
        end
    end

    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (apb_req && !pwrite && addr_ok && !hit_fdata) begin
            prdata_nxt = rd_mux;
        end else if ((state_r == ST_EXECUTE) && !pend_instr_r) begin
            prdata_nxt[7:0] = mem_rdata;
        end
    end

    // Answer stands for exactly one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= (state_nxt == ST_RESPOND);
            pslverr_r <= pslverr_nxt;
            if (state_nxt == ST_RESPOND) begin
                prdata_r <= prdata_nxt;
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign acc_out        = acc_r;
    assign carry_out      = carry_r;
    assign half_carry_out = half_carry_r;
    assign zero_out       = zero_r;
    assign retire_pulse   = retire_r;

endmodule // aie_core

// >>> verification/aie_core_props.sv
// Purpose: Concurrent checks on the ports of the accumulator execution block.
// Assumes: APB master holds each request until pready; one transfer at a time.
// Notes:   Operands are captured when an instruction write is taken.
`timescale 1ns/1ns
`include "aie_regs.svh"

module aie_core_props #(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [7:0]        acc_out,
    input wire logic              carry_out,
    input wire logic              half_carry_out,
    input wire logic              zero_out,
    input wire logic              retire_pulse
);
    logic        pen_d_r;
    logic [13:0] w_r;
    logic [7:0]  a_r;
    logic        c_r;
    logic        h_r;
    logic        take_i;
    logic        legal;
    logic [8:0]  sum_w;
    logic [4:0]  hs;

    // First access cycle only, so a wait state is not taken twice
    assign take_i = psel && penable && !pen_d_r && pwrite && paddr == `AIE_OFF_INSTR;
    assign legal  = pwdata[13:9] == `AIE_PAT_ADD_IMM || pwdata[13:8] == `AIE_PAT_AND_IMM
                 || pwdata[13:8] == `AIE_PAT_ADD_REG || pwdata[13:8] == `AIE_PAT_AND_REG;
    assign sum_w  = a_r + w_r[7:0];
    assign hs     = a_r[3:0] + w_r[3:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pen_d_r <= 1'b0;
        else          pen_d_r <= penable;
    end

    always_ff @(posedge pclk) begin
        if (take_i) begin
            w_r <= pwdata[13:0];
            a_r <= acc_out;
            c_r <= carry_out;
            h_r <= half_carry_out;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_INSTR_LAT: assert property (take_i && legal |->
        !pready[*3] ##1 (pready && retire_pulse && !pslverr))
        else $error("instruction latency wrong");
    AST_REFUSE: assert property (take_i && !legal |->
        ##1 (pready && pslverr && !retire_pulse))
        else $error("bad opcode not refused");
    AST_ADD_IMM: assert property (retire_pulse && w_r[13:9] == `AIE_PAT_ADD_IMM |->
        acc_out == sum_w[7:0] && carry_out == sum_w[8] && half_carry_out == hs[4]
        && zero_out == (sum_w[7:0] == 8'h00))
        else $error("add immediate result wrong");
    AST_AND_IMM: assert property (retire_pulse && w_r[13:8] == `AIE_PAT_AND_IMM |->
        acc_out == (a_r & w_r[7:0]) && carry_out == c_r && half_carry_out == h_r
        && zero_out == ((a_r & w_r[7:0]) == 8'h00))
        else $error("and immediate result wrong");
    AST_DEST1: assert property (retire_pulse && w_r[13:12] == 2'b00 && w_r[7] |->
        acc_out == a_r)
        else $error("accumulator changed on dest 1");
    AST_AND_REG: assert property (retire_pulse && w_r[13:8] == `AIE_PAT_AND_REG |->
        carry_out == c_r && half_carry_out == h_r)
        else $error("and register touched carry");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    // A register write lands on the edge that raises pready, so both show together
    AST_STATE_HOLD: assert property (
        $changed({acc_out, carry_out, half_carry_out, zero_out})
        |-> retire_pulse || (pready && pwrite && !pslverr))
        else $error("state changed without cause");

    COV_ADD: cover property (retire_pulse && w_r[13:9] == `AIE_PAT_ADD_IMM && carry_out);
    COV_DEST1: cover property (retire_pulse && w_r[13:12] == 2'b00 && w_r[7]);
    COV_REFUSE: cover property (take_i && !legal);
endmodule // aie_core_props

bind aie_core aie_core_props #(.ADDR_W(ADDR_W)) props_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_out(acc_out),
    .carry_out(carry_out), .half_carry_out(half_carry_out), .zero_out(zero_out),
    .retire_pulse(retire_pulse));

// >>> verification/add_and_instruction_exec_test.sv
// Purpose: Self-checking bench for the accumulator execution block.
// Assumes: A shadow model of accumulator, flags and file registers.
// Notes:   File registers are all written first, their reset value is unknown.
`timescale 1ns/1ns
`include "aie_regs.svh"

module add_and_instruction_exec_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, carry_out, half_carry_out, zero_out, retire_pulse, err;
    logic [7:0]  acc_out, acc_m, freg_m [128];
    logic        c_m, h_m, z_m, ill_m;
    logic [15:0] ret_m;
    int          failures = 0, num_checks = 0, cyc = 0;

    aie_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_out(acc_out), .carry_out(carry_out),
        .half_carry_out(half_carry_out), .zero_out(zero_out), .retire_pulse(retire_pulse));

    always #5 pclk = ~pclk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until the rising edge that samples pready high; answer taken there
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    function automatic logic [9:0] add_res(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = a + b;
        h = a[3:0] + b[3:0];
        return {h[4], s};
    endfunction

    task automatic run_instr(input logic [13:0] w);
        logic [7:0] opnd, res;
        logic [9:0] s;
        logic       isreg, isadd, legal;
        isreg = w[13:12] == 2'b00;
        opnd  = isreg ? freg_m[w[6:0]] : w[7:0];
        isadd = w[13:9] == 5'h1F || w[13:8] == 6'h07;
        legal = isadd || w[13:8] == 6'h39 || w[13:8] == 6'h05;
        s     = add_res(acc_m, opnd);
        res   = isadd ? s[7:0] : (acc_m & opnd);
        apb(1, `AIE_OFF_INSTR, {18'h0, w});
        chk("refusal", err, !legal);
        if (legal) begin
            ret_m++;
            z_m = res == 8'h00;
            if (isadd) {h_m, c_m} = s[9:8];
            if (isreg && w[7]) freg_m[w[6:0]] = res;
            else acc_m = res;
        end
        else ill_m = 1;
        chk("acc", acc_out, acc_m);
        chk("flags", {half_carry_out, carry_out, zero_out}, {h_m, c_m, z_m});
        if (isreg) begin
            apb(1, `AIE_OFF_FADDR, w[6:0]);
            apb(0, `AIE_OFF_FDATA, 0);
            chk("freg", rd, freg_m[w[6:0]]);
        end
    endtask

    task automatic set_acc(input logic [7:0] v);
        apb(1, `AIE_OFF_ACC, v);
        acc_m = v;
    endtask

    initial begin
        void'($urandom(32'h0000_de8d));
        {acc_m, c_m, h_m, z_m, ill_m, ret_m} = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, `AIE_OFF_RETIRED, 0);
        chk("retired_rst", rd, 0);
        apb(0, `AIE_OFF_STATUS, 0);
        chk("status_rst", rd, 0);
        for (int i = 0; i < 128; i++) begin
            freg_m[i] = $urandom;
            apb(1, `AIE_OFF_FADDR, i);
            apb(1, `AIE_OFF_FDATA, freg_m[i]);
        end
        // Worked cases: carry and zero together, both bit-8 values, index ends
        set_acc(8'h10); run_instr(14'h3E15);
        set_acc(8'hFF); run_instr(14'h3F01);
        set_acc(8'hA3); run_instr(14'h395F);
        run_instr(14'h3900);
        set_acc(8'h17); run_instr(14'h0780);
        run_instr(14'h05FF);
        run_instr(14'h0700);
        run_instr(14'h1234);
        for (int n = 0; n < 300; n++) begin
            int op;
            op = $urandom_range(0, 4);
            if ($urandom_range(0, 2) == 0) set_acc($urandom);
            case (op)
                0: run_instr({5'h1F, 9'($urandom)});
                1: run_instr({6'h39, 8'($urandom)});
                2: run_instr({6'h07, 8'($urandom)});
                3: run_instr({6'h05, 8'($urandom)});
                default: run_instr({2'b01, 12'($urandom)});
            endcase
        end
        apb(0, `AIE_OFF_STATUS, 0);
        chk("status", rd, {ill_m, z_m, h_m, c_m});
        apb(1, `AIE_OFF_STATUS, 32'h0000_0008);
        apb(0, `AIE_OFF_STATUS, 0);
        chk("status_clr", rd, 0);
        apb(1, `AIE_OFF_RETIRED, 32'h0000_1234);
        chk("ro_refused", err, 1);
        apb(0, 12'h018, 0);
        chk("unmapped", err, 1);
        apb(0, `AIE_OFF_RETIRED, 0);
        chk("retired", rd, ret_m);
        test_done();
    end
endmodule // add_and_instruction_exec_test
